// ==== lofm_pkg.sv ====
package lofm_pkg;
    // register offsets (byte addresses on the internal register port)
    localparam logic [7:0] LOFM_DET_CFG_FIRST  = 8'h84;
    localparam logic [7:0] LOFM_DET_CFG_LAST   = 8'h8f;
    localparam logic [7:0] LOFM_FLAGS_FIRST    = 8'h90;
    localparam logic [7:0] LOFM_FLAGS_LAST     = 8'h93;
    localparam logic [7:0] LOFM_FTYPE_LOW      = 8'h94;
    localparam logic [7:0] LOFM_FTYPE_HIGH     = 8'h95;
    localparam logic [7:0] LOFM_MASK_LOW       = 8'h96;
    localparam logic [7:0] LOFM_MASK_HIGH      = 8'h97;
    localparam logic [7:0] LOFM_CRC_COUNT      = 8'h98;
    // det_cfg field layout
    localparam int         LOFM_CFG_OPEN_EN    = 7;
    localparam int         LOFM_CFG_SHORT_EN   = 6;
    localparam int         LOFM_CFG_OPEN_TH_LO = 4;
    localparam int         LOFM_CFG_SHORT_TH_LO = 0;
    localparam logic [1:0] LOFM_OPEN_TH_20V    = 2'h3;
    localparam logic [3:0] LOFM_SHORT_TH_1V    = 4'h0;
    localparam logic [7:0] LOFM_DET_CFG_RESET  = 8'h30;
    // fault_type_low bits
    localparam int         LOFM_FT_SHORT       = 0;
    localparam int         LOFM_FT_OPEN        = 1;
    localparam int         LOFM_FT_CRC         = 2;
    localparam int         LOFM_FT_WDOG        = 3;
    localparam logic [7:0] LOFM_MASK_RESET     = 8'hff;
    localparam int         LOFM_CHANNELS       = 12;
    localparam int         LOFM_OPEN_PULSE_CYC = 4;
endpackage

// ==== lofm_monitor.sv ====
`timescale 1ns/1ps
// Function
// - each channel has its own open detect enable; disabled never flags open
// - each channel has its own short detect enable; disabled never flags short
// - open threshold picks 5, 10, 15 or 20 V, reset selects 20 V
// - short threshold picks 1 V to 16 V, reset selects 1 V
// - open comparator high briefly turns bypass on and sets open flag
// - short comparator sampled at LED on phase end sets short flag
// - fault flags stay latched until host writes 0
// - summary short bit set while any short flag set
// - summary open bit set while any open flag set
// - fault categories held in the low fault type register; the high one is never set
// - two mask registers choose which faults pull fault pin
// - CRC error counter increments once per failed frame
// - update then writing watchdog bit 0 leaves fail-safe, releases pin
module lofm_monitor
    import lofm_pkg::*;
#(
    parameter int CHANNELS = LOFM_CHANNELS
) (
    input  wire logic                core_clk,
    input  wire logic                reset_n,
    input  wire logic                clk_en,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    output logic      [7:0]          reg_rdata,
    input  wire logic [CHANNELS-1:0] open_cmp,
    input  wire logic [CHANNELS-1:0] short_cmp,
    input  wire logic [CHANNELS-1:0] led_on_end,
    input  wire logic                crc_error,
    input  wire logic                update_cmd,
    input  wire logic                watchdog_timeout,
    output logic [CHANNELS-1:0]      open_bypass_on,
    output logic [CHANNELS*2-1:0]    open_threshold_sel,
    output logic [CHANNELS*4-1:0]    short_threshold_sel,
    output logic                     fail_safe,
    output logic                     watchdog_restart,
    output logic                     fault_pin_n_o,
    output logic                     fault_pin_n_oe
);

    // complete block state in one packed word
    // cfg holds the per-channel detection bytes as written by the host
    // open_flag and short_flag are the latched channel faults
    // pulse_cnt counts down the short bypass burst after a new open fault
    // sum_open and sum_short are the sticky summary bits of the low fault type byte
    // crc_flag marks that at least one bad frame arrived since the last clear
    // wdog_flag is the fail-safe state itself
    // update_seen remembers an update command received while in fail-safe
    // restart is the one-cycle watchdog restart request
    // rdata is the registered read data, zero when no read is under way
    typedef struct packed {
        logic [CHANNELS-1:0][7:0] cfg;
        logic [CHANNELS-1:0]      open_flag;
        logic [CHANNELS-1:0]      short_flag;
        logic [CHANNELS-1:0][2:0] pulse_cnt;
        logic                     sum_open;
        logic                     sum_short;
        logic                     crc_flag;
        logic                     wdog_flag;
        logic                     update_seen;
        logic                     restart;
        logic [7:0]               ftype_high;
        logic [7:0]               mask_low;
        logic [7:0]               mask_high;
        logic [7:0]               crc_count;
        logic [7:0]               rdata;
    } lofm_state_t;

    lofm_state_t s_q;
    lofm_state_t s_d;

    // index of a flag register byte within the flag vector
    function automatic logic [1:0] lofm_flag_idx(input logic [7:0] a);
        lofm_flag_idx = 2'(a - LOFM_FLAGS_FIRST);
    endfunction

    // address lies in the detection configuration block
    function automatic logic lofm_is_cfg(input logic [7:0] a);
        lofm_is_cfg = (a >= LOFM_DET_CFG_FIRST) && (a <= LOFM_DET_CFG_LAST);
    endfunction

    // address lies in the latched channel flag block
    function automatic logic lofm_is_flag(input logic [7:0] a);
        lofm_is_flag = (a >= LOFM_FLAGS_FIRST) && (a <= LOFM_FLAGS_LAST);
    endfunction

    // channel index of a detection configuration byte
    function automatic logic [3:0] lofm_cfg_idx(input logic [7:0] a);
        lofm_cfg_idx = 4'(a - LOFM_DET_CFG_FIRST);
    endfunction

    // write-zero-to-clear merge: a written 1 leaves the stored bit alone
    function automatic logic [7:0] lofm_w0c(input logic [7:0] cur, input logic [7:0] wd);
        lofm_w0c = cur & wd;
    endfunction

    // flag vector layout
    // bytes 0 and 1 carry the open flags, channel 0 in bit 0
    // bytes 2 and 3 carry the short flags in the same order
    // the upper nibble of bytes 1 and 3 is unused and reads as zero
    // both write merge and read mux work on this one view,
    // so the byte pairing cannot drift between the two paths

    // packed view of flags: 90h..91h open ch0-11, 92h..93h short ch0-11
    logic [31:0] flag_vec;
    logic [7:0]  ftype_low;
    logic        any_open;
    logic        any_short;

    assign flag_vec  = {4'h0, s_q.short_flag, 4'h0, s_q.open_flag};
    assign any_open  = |s_q.open_flag;
    assign any_short = |s_q.short_flag;
    assign ftype_low = {4'h0, s_q.wdog_flag, s_q.crc_flag, s_q.sum_open, s_q.sum_short};

    // next state
    // order inside this process matters:
    // host writes are applied first, hardware events after them,
    // so a fault that shows in the same cycle as its clear survives
    // the restart request is a pulse and is dropped every cycle
    always_comb begin
        logic [31:0] fv;
        fv = flag_vec;
        s_d = s_q;
        s_d.restart = 1'b0;
        // register writes
        // configuration and mask bytes are plain storage
        // flag and fault type bytes only ever lose bits through a host write
        // the crc counter offset is read-only, writes to it fall through
        if (reg_wr) begin
            if (lofm_is_cfg(reg_addr)) begin
                s_d.cfg[lofm_cfg_idx(reg_addr)] = reg_wdata;
            end
            if (lofm_is_flag(reg_addr)) begin
                fv[lofm_flag_idx(reg_addr)*8 +: 8] =
                    lofm_w0c(fv[lofm_flag_idx(reg_addr)*8 +: 8], reg_wdata);
            end
            // low fault type byte: each bit has its own clear condition
            // summary bits refuse the clear while a channel flag stands
            // the watchdog bit refuses it until an update command was seen
            if (reg_addr == LOFM_FTYPE_LOW) begin
                if (!reg_wdata[LOFM_FT_OPEN] && !any_open) begin
                    s_d.sum_open = 1'b0;
                end
                if (!reg_wdata[LOFM_FT_SHORT] && !any_short) begin
                    s_d.sum_short = 1'b0;
                end
                if (!reg_wdata[LOFM_FT_CRC]) begin
                    s_d.crc_flag = 1'b0;
                end
                if (!reg_wdata[LOFM_FT_WDOG] && s_q.update_seen) begin
                    s_d.wdog_flag = 1'b0;
                    s_d.update_seen = 1'b0;
                    s_d.restart = 1'b1;
                end
            end
            if (reg_addr == LOFM_FTYPE_HIGH) begin
                s_d.ftype_high = s_q.ftype_high & reg_wdata;
            end
            if (reg_addr == LOFM_MASK_LOW) begin
                s_d.mask_low = reg_wdata;
            end
            if (reg_addr == LOFM_MASK_HIGH) begin
                s_d.mask_high = reg_wdata;
            end
        end
        // unpack the merged flag view back into the state
        s_d.open_flag  = fv[CHANNELS-1:0];
        s_d.short_flag = fv[16 +: CHANNELS];
        // hardware detection; set wins over a same-cycle clear
        // the open comparator is a level and is looked at every cycle,
        // the bypass burst starts only when the flag was not yet set,
        // so a lasting open does not keep the switch pulsing
        // the short comparator is looked at only on the end-of-phase pulse,
        // while the switch voltage has settled for the on phase
        for (int i = 0; i < CHANNELS; i++) begin
            if (s_q.pulse_cnt[i] != 3'h0) begin
                s_d.pulse_cnt[i] = s_q.pulse_cnt[i] - 3'h1;
            end
            if (s_q.cfg[i][LOFM_CFG_OPEN_EN] && open_cmp[i]) begin
                s_d.open_flag[i] = 1'b1;
                if (!s_q.open_flag[i]) begin
                    s_d.pulse_cnt[i] = 3'(LOFM_OPEN_PULSE_CYC);
                end
            end
            if (s_q.cfg[i][LOFM_CFG_SHORT_EN] && led_on_end[i] && short_cmp[i]) begin
                s_d.short_flag[i] = 1'b1;
            end
        end
        // summary bits follow the next flag state, not the current one,
        // so a fault and its summary bit become visible in the same cycle
        // summary open and short
        if (|s_d.open_flag) begin
            s_d.sum_open = 1'b1;
        end
        if (|s_d.short_flag) begin
            s_d.sum_short = 1'b1;
        end
        // crc counting
        // the counter wraps at its top value; the flag records any error
        if (crc_error) begin
            s_d.crc_count = s_q.crc_count + 8'h1;
            s_d.crc_flag = 1'b1;
        end
        // fail-safe entry and the first half of its exit
        // an update command counts only while fail-safe is active
        // a timeout in the same cycle as the exit write keeps fail-safe
        // and cancels the restart pulse
        if (update_cmd && s_q.wdog_flag) begin
            s_d.update_seen = 1'b1;
        end
        if (watchdog_timeout) begin
            s_d.wdog_flag = 1'b1;
            s_d.restart = 1'b0;
        end
        // read data mux
        // data is registered and stands for one cycle after the read
        // unmapped addresses and idle cycles give zero
        s_d.rdata = 8'h0;
        if (reg_rd) begin
            if (lofm_is_cfg(reg_addr)) begin
                s_d.rdata = s_q.cfg[lofm_cfg_idx(reg_addr)];
            end else if (lofm_is_flag(reg_addr)) begin
                s_d.rdata = flag_vec[lofm_flag_idx(reg_addr)*8 +: 8];
            end else begin
                case (reg_addr)
                    LOFM_FTYPE_LOW:  s_d.rdata = ftype_low;
                    LOFM_FTYPE_HIGH: s_d.rdata = s_q.ftype_high;
                    LOFM_MASK_LOW:   s_d.rdata = s_q.mask_low;
                    LOFM_MASK_HIGH:  s_d.rdata = s_q.mask_high;
                    LOFM_CRC_COUNT:  s_d.rdata = s_q.crc_count;
                    default:         s_d.rdata = 8'h0;
                endcase
            end
        end
    end

    // state register
    // reset loads detection disabled, 20 V open and 1 V short thresholds
    // and every fault reporting mask enabled
    // a low clock enable holds every bit, including the read data
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
            for (int i = 0; i < CHANNELS; i++) begin
                s_q.cfg[i] <= LOFM_DET_CFG_RESET;
            end
            s_q.mask_low  <= LOFM_MASK_RESET;
            s_q.mask_high <= LOFM_MASK_RESET;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // threshold selects and bypass pulse outputs
    // both threshold selects come straight from state bits; open_bypass_on is a nonzero decode of pulse_cnt
    // threshold codes: open 0 to 3 for 5 V steps, short 0 to 15 for 1 V steps
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_ch
            assign open_threshold_sel[g*2 +: 2]  = s_q.cfg[g][LOFM_CFG_OPEN_TH_LO +: 2];
            assign short_threshold_sel[g*4 +: 4] = s_q.cfg[g][LOFM_CFG_SHORT_TH_LO +: 4];
            assign open_bypass_on[g] = s_q.pulse_cnt[g] != 3'h0;
        end
    endgenerate

    // fault pin: open drain, the data is fixed low and only the enable moves
    // a set fault type bit pulls the pin only while its mask bit is set
    // the pin is released once every masked-in fault bit is cleared
    // masks gate
    assign fault_pin_n_oe   = |((ftype_low & s_q.mask_low) | (s_q.ftype_high & s_q.mask_high));
    assign fault_pin_n_o    = 1'b0;
    assign fail_safe        = s_q.wdog_flag;
    assign watchdog_restart = s_q.restart;
    assign reg_rdata        = s_q.rdata;

endmodule

// ==== lofm_properties.sv ====
`timescale 1ns/1ps
module lofm_properties #(parameter int CHANNELS = 12) (
    input logic                core_clk,
    input logic                reset_n,
    input logic [CHANNELS-1:0] open_cmp,
    input logic [CHANNELS-1:0] open_bypass_on,
    input logic                watchdog_timeout,
    input logic                fail_safe,
    input logic                watchdog_restart,
    input logic                fault_pin_n_o
);
    // bypass burst, fail-safe exit and pin checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    sequence s_burst; open_bypass_on[0] [*4]; endsequence
    property p_pin; fault_pin_n_o == 1'b0; endproperty
    a_pin: assert property (p_pin) else $error("pin output high");
    property p_burst; $rose(open_bypass_on[0]) |-> s_burst; endproperty
    a_burst: assert property (p_burst) else $error("burst short");
    property p_src; $rose(open_bypass_on[0]) |-> $past(open_cmp[0]); endproperty
    a_src: assert property (p_src) else $error("burst without open");
    property p_idle; !open_cmp[11] && !open_bypass_on[11] |=> !open_bypass_on[11]; endproperty
    a_idle: assert property (p_idle) else $error("burst on healthy led");
    property p_wdog; $rose(fail_safe) |-> $past(watchdog_timeout); endproperty
    a_wdog: assert property (p_wdog) else $error("fail safe unprompted");
    property p_exit; watchdog_restart |-> !fail_safe; endproperty
    a_exit: assert property (p_exit) else $error("restart in fail safe");
    property p_pulse; watchdog_restart |=> !watchdog_restart; endproperty
    a_pulse: assert property (p_pulse) else $error("restart too long");
    property p_rst; disable iff (1'b0) !reset_n |-> !fail_safe && open_bypass_on == '0; endproperty
    a_rst: assert property (p_rst) else $error("active in reset");
endmodule
bind lofm_monitor lofm_properties #(.CHANNELS(CHANNELS)) chk_u (.*);

// ==== lofm_host.sv ====
`timescale 1ns/1ps
module lofm_host (
    input  logic       core_clk,
    output logic       reg_wr,
    output logic       reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input  logic [7:0] reg_rdata
);
    // bus idle at time zero
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge core_clk) {reg_wr, reg_wdata} <= {1'b0, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge core_clk) reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic clear_all;
        for (int i = 0; i < 5; i++) wr(8'h90 + 8'(i), 8'h00);
    endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic        core_clk = 1'b0, reset_n = 1'b0, crc_error = 1'b0, update_cmd = 1'b0;
    logic        clk_en = 1'b1;
    logic [23:0] open_sel;
    logic [47:0] short_sel;
    logic        watchdog_timeout = 1'b0, reg_wr, reg_rd, fail_safe, fault_pin_n_oe;
    logic [11:0] open_cmp = '0, short_cmp = '0, led_on_end = '0;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
    int          fails = 0, cmp_count = 0;
    logic [24:0] rows [7] = '{25'h0840030, 25'h09600ff, 25'h0980000, 25'h184c5c5,
        25'h18fc5c5, 25'h199_5a00, 25'h1985500};
    // clock, device and host model
    always #2.5 core_clk = ~core_clk;
    lofm_monitor dut_u (.*, .open_bypass_on(), .open_threshold_sel(open_sel),
        .short_threshold_sel(short_sel), .watchdog_restart(), .fault_pin_n_o());
    lofm_host host_u (.*);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        fails += int'(seen !== exp);
        if (seen !== exp) $display("BAD %0t got %h want %h", $time, seen, exp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a, d);
        check(d, e);
    endtask
    task automatic give_verdict;
        if (fails == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // reset, register rows, then open, short, crc and watchdog faults
    initial begin
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i][24]) host_u.wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        check(open_sel[7:0], 8'hfc);
        check(short_sel[7:0], 8'h05);
        @(posedge core_clk) open_cmp <= 12'hfff;
        repeat (6) @(posedge core_clk);
        open_cmp <= '0;
        host_u.wr(8'h90, 8'hff);
        rd(8'h90, 8'h01);
        check(8'(fault_pin_n_oe), 8'h01);
        host_u.wr(8'h94, 8'h00);
        rd(8'h94, 8'h02);
        host_u.clear_all();
        @(posedge core_clk) short_cmp <= 12'hfff;
        @(posedge core_clk) led_on_end <= 12'hfff;
        @(posedge core_clk) led_on_end <= '0;
        rd(8'h93, 8'h08);
        rd(8'h94, 8'h01);
        @(posedge core_clk) crc_error <= 1'b1;
        repeat (3) @(posedge core_clk);
        {crc_error, watchdog_timeout} <= 2'b01;
        @(posedge core_clk) watchdog_timeout <= 1'b0;
        rd(8'h98, 8'h03);
        host_u.clear_all();
        rd(8'h94, 8'h08);
        @(posedge core_clk) update_cmd <= 1'b1;
        @(posedge core_clk) update_cmd <= 1'b0;
        host_u.clear_all();
        rd(8'h94, 8'h00);
        check(8'(fail_safe), 8'h00);
        // frozen clock enable: a crc error pulse must not count
        @(posedge core_clk) {clk_en, crc_error} <= 2'b01;
        @(posedge core_clk) {clk_en, crc_error} <= 2'b10;
        rd(8'h98, 8'h03);
        // mid-run reset: thresholds and configuration back to defaults
        @(posedge core_clk) reset_n <= 1'b0;
        @(posedge core_clk) check(open_sel[7:0], 8'hff);
        check(short_sel[7:0], 8'h00);
        reset_n <= 1'b1;
        rd(8'h84, 8'h30);
        give_verdict;
    end
    // hang guard
    initial begin
        #20000 fails++;
        give_verdict;
    end
endmodule
